// ### logic/bsr_snoop.sv
// Summary of operation
// - Read-for-ownership snoop actions apply only when the global qualifier is set.
// - Read-for-ownership missing the cache causes no snoop action.
// - Read-for-ownership hitting status_a or exclusive block makes it invalid.
// - Read-for-ownership hitting modified: retry, status_a status; unless a castout is in flight, push block, make invalid.
// - Store-conditional issues atomic ownership read; atomic form snooped like plain.
// - Translation-sync instruction issues an address-only translation-sync transaction.
// - Snooped translation-sync retried while invalidated-translation operations pend.
// - Translation-invalidate issues address-only transaction carrying address bits 12 to 19.
// - Second translation-invalidate snooped while one pends is retried.
// - I/O reply is the last transaction of a direct-store sequence.
// - Memory-sync instruction issues an address-only sync transaction.
// - Snooped sync retried while another snooped cache operation is pending.
// - Noncaching read hitting modified: unless a castout is in flight, write block back, make it exclusive.
`timescale 1ns/100ps
`default_nettype none
module bsr_snoop
    import bsr_pkg::*;
#(
    parameter int ADDR_W = 32
) (
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire logic              snp_valid,
    input  wire logic [4:0]        transfer_type_code,
    input  wire logic [ADDR_W-1:0] snp_addr,
    input  wire logic              global_coherent_qual,
    input  wire bsr_mesi_t         snp_state,
    input  wire logic              tlb_op_pending,
    input  wire logic              tlb_inv_done,
    input  wire logic              push_done,
    output logic                   address_retry,
    output logic                   status_a,
    output logic                   upd_valid,
    output bsr_mesi_t              upd_state,
    output logic [ADDR_W-1:0]      upd_addr,
    output logic                   push_req,
    output logic [ADDR_W-1:0]      push_addr,
    output logic                   tlb_inv,
    output logic [CC_IDX_W-1:0]    tlb_inv_idx,
    input  wire logic              cmd_valid,
    input  wire bsr_cmd_t          cmd_op,
    input  wire logic [ADDR_W-1:0] cmd_addr,
    output logic                   cmd_ready,
    output logic                   mst_valid,
    output logic [4:0]             mst_type,
    output logic [ADDR_W-1:0]      mst_addr,
    input  wire logic              mst_ack
);
    logic              retry_q, retry_d;
    logic              stat_q, stat_d;
    logic              upd_q, upd_d;
    bsr_mesi_t         ust_q, ust_d;
    logic [ADDR_W-1:0] uaddr_q;
    logic              push_q, push_d;
    logic              push_busy_q;
    logic              tinv_q, tinv_d;
    logic [CC_IDX_W-1:0] tidx_q;
    logic              tinv_pend_q;
    logic              mv_q;
    logic [4:0]        mtt_q;
    logic [ADDR_W-1:0] maddr_q;
    logic              ds_open_q;
    logic              is_rfo, is_ncr, is_tsync, is_tinv, is_sync;
    logic              hit_m, hit_clean, cmd_take;

    // Snooped transaction decode; atomic and plain ownership reads share a path
    assign is_rfo   = snp_valid && global_coherent_qual
                   && (transfer_type_code == BT_RFO || transfer_type_code == BT_RFO_ATOMIC);
    assign is_ncr   = snp_valid && (transfer_type_code == BT_NC_READ);
    assign is_tsync = snp_valid && (transfer_type_code == BT_TLBSYNC);
    assign is_tinv  = snp_valid && (transfer_type_code == BT_TLBINV);
    assign is_sync  = snp_valid && (transfer_type_code == BT_SYNC);
    assign hit_m     = (snp_state == BSR_MODIFIED_STATE);
    assign hit_clean = (snp_state == BSR_STATUS_A) || (snp_state == BSR_EXCLUSIVE);

    // Snoop response and cache action for the current address tenure
    always_comb begin
        retry_d = 1'b0;
        stat_d  = 1'b0;
        upd_d   = 1'b0;
        ust_d   = BSR_INVALID_STATE;
        push_d  = 1'b0;
        tinv_d  = 1'b0;
        if (is_rfo) begin
            if (hit_m) begin
                retry_d = 1'b1;
                stat_d  = 1'b1;
                if (!push_busy_q) begin
                    push_d = 1'b1;
                    upd_d  = 1'b1;
                end
            end else if (hit_clean) begin
                upd_d = 1'b1;
            end
        end else if (is_ncr) begin
            if (hit_m) begin
                retry_d = 1'b1;
                if (!push_busy_q) begin
                    push_d = 1'b1;
                    upd_d  = 1'b1;
                    ust_d  = BSR_EXCLUSIVE;
                end
            end
        end else if (is_tsync) begin
            retry_d = tlb_op_pending;
        end else if (is_tinv) begin
            if (tinv_pend_q) begin
                retry_d = 1'b1;
            end else begin
                tinv_d = 1'b1;
            end
        end else if (is_sync) begin
            retry_d = push_busy_q || tinv_pend_q;
        end
    end

    // Registered snoop outputs, one cycle after the snooped tenure
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            retry_q <= 1'b0;
            stat_q  <= 1'b0;
            upd_q   <= 1'b0;
            ust_q   <= BSR_INVALID_STATE;
            uaddr_q <= '0;
            push_q  <= 1'b0;
            tinv_q  <= 1'b0;
            tidx_q  <= '0;
        end else begin
            retry_q <= retry_d;
            stat_q  <= stat_d;
            upd_q   <= upd_d;
            ust_q   <= ust_d;
            uaddr_q <= snp_addr;
            push_q  <= push_d;
            tinv_q  <= tinv_d;
            tidx_q  <= snp_addr[CC_IDX_MSB:CC_IDX_LSB];
        end
    end

    // Castout in flight; a new push wins over a completion in the same cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            push_busy_q <= 1'b0;
        end else if (push_d) begin
            push_busy_q <= 1'b1;
        end else if (push_done) begin
            push_busy_q <= 1'b0;
        end
    end

    // Translation invalidation in flight, set wins over done
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            tinv_pend_q <= 1'b0;
        end else if (tinv_d) begin
            tinv_pend_q <= 1'b1;
        end else if (tlb_inv_done) begin
            tinv_pend_q <= 1'b0;
        end
    end

    assign address_retry = retry_q;
    assign status_a      = stat_q;
    assign upd_valid     = upd_q;
    assign upd_state     = ust_q;
    assign upd_addr      = uaddr_q;
    assign push_req      = push_q;
    assign push_addr     = uaddr_q;
    assign tlb_inv       = tinv_q;
    assign tlb_inv_idx   = tidx_q;

    // Issuer takes one command at a time, so program order is bus order
    assign cmd_ready = !mv_q && (!ds_open_q || cmd_op == BSR_CMD_DS_XFER
                               || cmd_op == BSR_CMD_IO_REPLY);
    assign cmd_take  = cmd_valid && cmd_ready;

    // Command to transfer type
    function automatic logic [4:0] bsr_type_of(input bsr_cmd_t op);
        logic [4:0] ty;
        ty = BT_SYNC;
        unique case (op)
            BSR_CMD_SYNC:     ty = BT_SYNC;
            BSR_CMD_EIEIO:    ty = BT_EIEIO;
            BSR_CMD_TLBSYNC:  ty = BT_TLBSYNC;
            BSR_CMD_TLBINV:   ty = BT_TLBINV;
            BSR_CMD_STCX:     ty = BT_RFO_ATOMIC;
            BSR_CMD_NC_RD:    ty = BT_READ;
            BSR_CMD_NC_WR:    ty = BT_NC_WRITE;
            BSR_CMD_DS_XFER:  ty = BT_DS_XFER;
            BSR_CMD_IO_REPLY: ty = BT_IO_REPLY;
            default:          ty = BT_SYNC;
        endcase
        return ty;
    endfunction : bsr_type_of

    // Bus request register held until the bus acknowledges it
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mv_q    <= 1'b0;
            mtt_q   <= BT_SYNC;
            maddr_q <= '0;
        end else if (cmd_take) begin
            mv_q  <= 1'b1;
            mtt_q <= bsr_type_of(cmd_op);
            if (cmd_op == BSR_CMD_SYNC || cmd_op == BSR_CMD_EIEIO
                || cmd_op == BSR_CMD_TLBSYNC) begin
                maddr_q <= '0;
            end else if (cmd_op == BSR_CMD_TLBINV) begin
                maddr_q <= cmd_addr & CC_IDX_MASK[ADDR_W-1:0];
            end else begin
                maddr_q <= cmd_addr;
            end
        end else if (mst_ack) begin
            mv_q <= 1'b0;
        end
    end

    // Direct-store sequence open until its I/O reply is issued
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ds_open_q <= 1'b0;
        end else if (cmd_take && cmd_op == BSR_CMD_DS_XFER) begin
            ds_open_q <= 1'b1;
        end else if (cmd_take && cmd_op == BSR_CMD_IO_REPLY) begin
            ds_open_q <= 1'b0;
        end
    end

    assign mst_valid = mv_q;
    assign mst_type  = mtt_q;
    assign mst_addr  = maddr_q;

    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    AST_RFO_NEEDS_QUAL: assert property (
        snp_valid && !global_coherent_qual && transfer_type_code == BT_RFO
        |=> !upd_valid && !push_req && !status_a)
        else $error("ownership read acted without global qualifier");
    AST_RFO_MISS_QUIET: assert property (
        is_rfo && snp_state == BSR_INVALID_STATE
        |=> !upd_valid && !push_req && !address_retry)
        else $error("ownership read miss caused an action");
    AST_RFO_CLEAN_DROP: assert property (
        is_rfo && hit_clean |=> upd_valid && upd_state == BSR_INVALID_STATE && !address_retry)
        else $error("clean hit not invalidated");
    AST_RFO_MOD: assert property (
        is_rfo && hit_m && !push_busy_q
        |=> address_retry && status_a && push_req && upd_state == BSR_INVALID_STATE
            ##1 push_busy_q)
        else $error("modified ownership hit response wrong");
    AST_STCX_ATOMIC: assert property (
        cmd_take && cmd_op == BSR_CMD_STCX |=> mst_valid && mst_type == BT_RFO_ATOMIC)
        else $error("store-conditional not issued as atomic ownership read");
    AST_TSYNC_RETRY: assert property (
        is_tsync |=> address_retry == $past(tlb_op_pending))
        else $error("translation sync retry wrong");
    AST_TINV_ADDR: assert property (
        cmd_take && cmd_op == BSR_CMD_TLBINV
        |=> mst_type == BT_TLBINV && (mst_addr & ~CC_IDX_MASK[ADDR_W-1:0]) == '0)
        else $error("translation invalidate address wrong");
    AST_TINV_SECOND: assert property (
        is_tinv && tinv_pend_q |=> address_retry && !tlb_inv)
        else $error("second invalidate not retried");
    AST_TINV_INDEX: assert property (
        is_tinv && !tinv_pend_q
        |=> tlb_inv && tlb_inv_idx == $past(snp_addr[CC_IDX_MSB:CC_IDX_LSB]))
        else $error("congruence class invalidate missing");
    AST_DS_REPLY_LAST: assert property (
        ds_open_q && cmd_valid && cmd_op != BSR_CMD_DS_XFER
        && cmd_op != BSR_CMD_IO_REPLY |-> !cmd_ready)
        else $error("access accepted inside open direct-store sequence");
    AST_SYNC_RETRY: assert property (
        is_sync |=> address_retry == ($past(push_busy_q) || $past(tinv_pend_q)))
        else $error("sync retry wrong");
    AST_NCR_MOD: assert property (
        is_ncr && hit_m && !push_busy_q
        |=> push_req && upd_valid && upd_state == BSR_EXCLUSIVE)
        else $error("noncaching read modified hit wrong");
    AST_NCR_RETRY: assert property (
        is_ncr && hit_m |=> address_retry && !status_a)
        else $error("noncaching read modified hit not retried");
    AST_NCR_CLEAN: assert property (
        is_ncr && !hit_m |=> !upd_valid && !address_retry && !push_req)
        else $error("noncaching read clean hit acted");
    AST_ISSUE_HOLD: assert property (
        mst_valid && !mst_ack |=> mst_valid && $stable(mst_type) && !cmd_ready)
        else $error("bus request dropped before acknowledge");

    COV_RFO_MOD:  cover property (is_rfo && hit_m ##1 push_req);
    COV_NCR_MOD:  cover property (is_ncr && hit_m ##1 upd_valid);
    COV_TINV_2ND: cover property (is_tinv ##[1:8] is_tinv && tinv_pend_q);
    COV_EIEIO:    cover property (cmd_take && cmd_op == BSR_CMD_EIEIO);
    COV_SYNC_RT:  cover property (is_sync && tinv_pend_q ##1 address_retry);
endmodule : bsr_snoop
`default_nettype wire

// ### logic/bsr_pkg.sv
`default_nettype none
package bsr_pkg;
    // Cache block states of the data cache
    typedef enum logic [1:0] {
        BSR_INVALID_STATE  = 2'h0,
        BSR_STATUS_A         = 2'h1,
        BSR_EXCLUSIVE      = 2'h2,
        BSR_MODIFIED_STATE = 2'h3
    } bsr_mesi_t;

    // Commands that the core hands to the bus issuer
    typedef enum logic [3:0] {
        BSR_CMD_SYNC     = 4'h0,
        BSR_CMD_EIEIO    = 4'h1,
        BSR_CMD_TLBSYNC  = 4'h2,
        BSR_CMD_TLBINV   = 4'h3,
        BSR_CMD_STCX     = 4'h4,
        BSR_CMD_NC_RD    = 4'h5,
        BSR_CMD_NC_WR    = 4'h6,
        BSR_CMD_DS_XFER  = 4'h7,
        BSR_CMD_IO_REPLY = 4'h8
    } bsr_cmd_t;

    // Transfer type codes on the status_a bus
    localparam logic [4:0] BT_READ         = 5'h05;
    localparam logic [4:0] BT_NC_READ      = 5'h15;
    localparam logic [4:0] BT_RFO          = 5'h0E;
    localparam logic [4:0] BT_RFO_ATOMIC   = 5'h0F;
    localparam logic [4:0] BT_SYNC         = 5'h01;
    localparam logic [4:0] BT_EIEIO        = 5'h10;
    localparam logic [4:0] BT_TLBSYNC      = 5'h09;
    localparam logic [4:0] BT_TLBINV       = 5'h18;
    localparam logic [4:0] BT_NC_WRITE     = 5'h02;
    localparam logic [4:0] BT_DS_XFER      = 5'h1B;
    localparam logic [4:0] BT_IO_REPLY     = 5'h1A;

    // Effective address bits that select a translation congruence class
    localparam int         CC_IDX_LSB      = 12;
    localparam int         CC_IDX_MSB      = 19;
    localparam int         CC_IDX_W        = CC_IDX_MSB - CC_IDX_LSB + 1;
    localparam logic [31:0] CC_IDX_MASK    = 32'h000FF000;
endpackage : bsr_pkg
`default_nettype wire

// ### test/bsr_far_side.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_far_side (
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic mst_valid,
    input  wire logic push_req,
    input  wire logic tlb_inv,
    output logic      mst_ack,
    output logic      push_done,
    output logic      tlb_inv_done
);
    int wait_n = 0;
    int push_n = 0;
    int inv_n  = 0;
    bit slow   = 1'b0;

    initial begin
        mst_ack      = 1'b0;
        push_done    = 1'b0;
        tlb_inv_done = 1'b0;
    end

    // Take bus requests strictly in arrival order, alternately prompt and slow
    always @(posedge sys_clk) begin
        #1;
        mst_ack = 1'b0;
        if (!srst && mst_valid) begin
            if (wait_n >= (slow ? 3 : 0)) begin
                mst_ack = 1'b1;
                wait_n  = 0;
                slow    = !slow;
            end else begin
                wait_n++;
            end
        end
    end

    // Castouts and invalidations finish five cycles after they start
    always @(posedge sys_clk) begin
        #1;
        push_done    = (push_n == 1);
        tlb_inv_done = (inv_n == 1);
        push_n       = srst ? 0 : push_req ? 5 : (push_n > 0) ? push_n - 1 : 0;
        inv_n        = srst ? 0 : tlb_inv ? 5 : (inv_n > 0) ? inv_n - 1 : 0;
    end
endmodule : bsr_far_side
`default_nettype wire

// ### test/bsr_snoop_tb.sv
`timescale 1ns/100ps
`default_nettype none
module bsr_snoop_tb
    import bsr_pkg::*;
;
    typedef struct packed {
        logic rt; logic st; logic sc; logic uv; bsr_mesi_t us; logic pu; logic ti; logic [31:0] a;
    } bsr_note_t;

    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic        snp_valid = 1'b0;
    logic [4:0]  transfer_type_code = 5'h00;
    logic [31:0] snp_addr = 32'h0;
    logic        global_coherent_qual = 1'b0;
    bsr_mesi_t   snp_state = BSR_INVALID_STATE;
    logic        tlb_op_pending = 1'b0;
    logic        cmd_valid = 1'b0;
    bsr_cmd_t    cmd_op = BSR_CMD_SYNC;
    logic [31:0] cmd_addr = 32'h0;
    logic        address_retry, status_a, upd_valid, push_req, tlb_inv, cmd_ready;
    logic        mst_valid, mst_ack, push_done, tlb_inv_done;
    bsr_mesi_t   upd_state;
    logic [31:0] upd_addr, push_addr, mst_addr;
    logic [7:0]  tlb_inv_idx;
    logic [4:0]  mst_type;
    logic [31:0] seed = 32'h0000144C;
    int          bad_count = 0;
    int          comparisons = 0;
    logic        taken = 1'b0;
    bsr_note_t   sq[$];
    bsr_note_t   sn;
    logic [36:0] mq[$];
    logic [4:0]  rd_codes[3] = '{BT_RFO, BT_RFO_ATOMIC, BT_NC_READ};
    bsr_cmd_t    ops[8] = '{BSR_CMD_NC_RD, BSR_CMD_EIEIO, BSR_CMD_NC_WR, BSR_CMD_SYNC,
                            BSR_CMD_TLBSYNC, BSR_CMD_TLBINV, BSR_CMD_STCX, BSR_CMD_DS_XFER};
    logic [4:0]  type_codes[8] = '{BT_READ, BT_EIEIO, BT_NC_WRITE, BT_SYNC,
                            BT_TLBSYNC, BT_TLBINV, BT_RFO_ATOMIC, BT_DS_XFER};

    bsr_snoop dut (.sys_clk(sys_clk), .srst(srst), .snp_valid(snp_valid),
        .transfer_type_code(transfer_type_code), .snp_addr(snp_addr),
        .global_coherent_qual(global_coherent_qual), .snp_state(snp_state),
        .tlb_op_pending(tlb_op_pending), .tlb_inv_done(tlb_inv_done), .push_done(push_done),
        .address_retry(address_retry), .status_a(status_a), .upd_valid(upd_valid),
        .upd_state(upd_state), .upd_addr(upd_addr), .push_req(push_req), .push_addr(push_addr),
        .tlb_inv(tlb_inv), .tlb_inv_idx(tlb_inv_idx), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
        .cmd_addr(cmd_addr), .cmd_ready(cmd_ready), .mst_valid(mst_valid), .mst_type(mst_type),
        .mst_addr(mst_addr), .mst_ack(mst_ack));

    bsr_far_side far (.sys_clk(sys_clk), .srst(srst), .mst_valid(mst_valid),
        .push_req(push_req), .tlb_inv(tlb_inv), .mst_ack(mst_ack), .push_done(push_done),
        .tlb_inv_done(tlb_inv_done));

    // Clock
    always #5 sys_clk = ~sys_clk;

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t %s: saw %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (bad_count == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : end_of_test

    // One snoop tenure with its expected answer worked out beforehand
    task automatic snoop(input logic [4:0] t, input logic g, input bsr_mesi_t s, input logic pend);
        bsr_note_t n;
        n = '0;
        n.a = xs();
        n.sc = (t == BT_RFO) || (t == BT_RFO_ATOMIC) || (t == BT_NC_READ);
        if (g && (t == BT_RFO || t == BT_RFO_ATOMIC)) begin
            n.uv = (s != BSR_INVALID_STATE);
            n.rt = (s == BSR_MODIFIED_STATE);
            n.st = n.rt;
            n.pu = n.rt;
        end
        if (t == BT_NC_READ && s == BSR_MODIFIED_STATE) begin
            n.rt = 1'b1;
            n.uv = 1'b1;
            n.us = BSR_EXCLUSIVE;
            n.pu = 1'b1;
        end
        if (t == BT_SYNC || t == BT_TLBSYNC || t == BT_TLBINV) n.rt = pend;
        n.ti = (t == BT_TLBINV) && !pend;
        sq.push_back(n);
        @(posedge sys_clk) #1;
        snp_valid = 1'b1;
        transfer_type_code = t;
        snp_addr = n.a;
        global_coherent_qual = g;
        snp_state = s;
        @(posedge sys_clk) #1;
        snp_valid = 1'b0;
        snp_addr = ~n.a;
    endtask : snoop

    // One core command, held until taken
    task automatic do_cmd(input bsr_cmd_t op, input logic [4:0] t);
        logic [31:0] a;
        logic [31:0] e;
        logic        rdy;
        int          k;
        a = xs();
        case (op)
            BSR_CMD_TLBINV: e = a & CC_IDX_MASK;
            BSR_CMD_SYNC, BSR_CMD_EIEIO, BSR_CMD_TLBSYNC: e = 32'h0;
            default: e = a;
        endcase
        mq.push_back({t, e});
        @(posedge sys_clk) #1;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_addr = a;
        rdy = 1'b0;
        k = 0;
        while (!rdy && k < 50) begin
            @(negedge sys_clk) rdy = cmd_ready;
            @(posedge sys_clk);
            k++;
        end
        #1 cmd_valid = 1'b0;
        cmd_addr = ~a;
        if (!rdy) check(40'h1, 40'h0, "command never taken");
    endtask : do_cmd

    // Snoop answer monitor
    always @(posedge sys_clk) taken <= snp_valid && !srst;
    always @(negedge sys_clk) begin
        if (taken) begin
            sn = sq.pop_front();
            check({36'h0, address_retry, upd_valid, push_req, tlb_inv},
                  {36'h0, sn.rt, sn.uv, sn.pu, sn.ti}, "snoop answer");
            if (sn.sc) check({39'h0, status_a}, {39'h0, sn.st}, "status_a status");
            if (sn.uv) check({6'h0, upd_state, upd_addr}, {6'h0, sn.us, sn.a}, "state update");
            if (sn.pu) check({8'h0, push_addr}, {8'h0, sn.a}, "castout address");
            if (sn.ti) check({32'h0, tlb_inv_idx}, {32'h0, sn.a[19:12]}, "class index");
        end else if (!srst) begin
            check({36'h0, address_retry, upd_valid, push_req, tlb_inv}, 40'h0, "idle answer");
        end
    end

    // Bus request monitor
    always @(posedge sys_clk) begin
        if (mst_valid && mst_ack) begin
            check({3'h0, mst_type, mst_addr}, {3'h0, mq.pop_front()}, "bus request");
        end
    end

    // Watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        bad_count++;
        end_of_test();
    end

    // Main sequence
    initial begin
        repeat (16) @(posedge sys_clk);
        #1 srst = 1'b0;
        foreach (rd_codes[i]) for (int s = 0; s < 4; s++) begin
            snoop(rd_codes[i], 1'b1, bsr_mesi_t'(s), 1'b0);
            repeat (8) @(posedge sys_clk);
        end
        for (int i = 0; i < 12; i++) begin
            snoop(rd_codes[xs() % 3], 1'b1, bsr_mesi_t'(2'(xs())), 1'b0);
            repeat (8) @(posedge sys_clk);
        end
        snoop(BT_RFO, 1'b0, BSR_MODIFIED_STATE, 1'b0);
        snoop(BT_RFO_ATOMIC, 1'b0, BSR_STATUS_A, 1'b0);
        snoop(BT_RFO, 1'b1, BSR_MODIFIED_STATE, 1'b0);
        snoop(BT_SYNC, 1'b1, BSR_INVALID_STATE, 1'b1);
        repeat (8) @(posedge sys_clk);
        snoop(BT_SYNC, 1'b1, BSR_INVALID_STATE, 1'b0);
        snoop(BT_TLBINV, 1'b1, BSR_INVALID_STATE, 1'b0);
        snoop(BT_TLBINV, 1'b1, BSR_INVALID_STATE, 1'b1);
        snoop(BT_SYNC, 1'b1, BSR_INVALID_STATE, 1'b1);
        repeat (8) @(posedge sys_clk);
        #1 tlb_op_pending = 1'b1;
        snoop(BT_TLBSYNC, 1'b1, BSR_INVALID_STATE, 1'b1);
        @(posedge sys_clk) #1 tlb_op_pending = 1'b0;
        snoop(BT_TLBSYNC, 1'b1, BSR_INVALID_STATE, 1'b0);
        foreach (ops[i]) do_cmd(ops[i], type_codes[i]);
        repeat (6) @(posedge sys_clk);
        #1 cmd_valid = 1'b1;
        cmd_op = BSR_CMD_SYNC;
        @(negedge sys_clk) check({39'h0, cmd_ready}, 40'h0, "taken inside direct-store");
        @(posedge sys_clk) #1 cmd_valid = 1'b0;
        do_cmd(BSR_CMD_IO_REPLY, BT_IO_REPLY);
        do_cmd(BSR_CMD_SYNC, BT_SYNC);
        repeat (10) @(posedge sys_clk);
        check(40'(sq.size() + mq.size()), 40'h0, "notes left over");
        end_of_test();
    end
endmodule : bsr_snoop_tb
`default_nettype wire
